// ==== blc_pkg.sv ====
// shared constants for the bit clock loop control register bank
package blc_pkg;

  // register indexes; byte address on the bus is four times the index
  localparam logic [7:0] IDX_LOCK_SELECT = 8'h00;
  localparam logic [7:0] IDX_BW_SELECT   = 8'h01;
  localparam logic [7:0] IDX_STATUS      = 8'h02;

  // reset values of the written control images
  localparam logic [7:0] RST_LOCK_SELECT = 8'h40;
  localparam logic [7:0] RST_BW_SELECT   = 8'h00;

  // lock select field layout
  localparam int LOCK_OVERRIDE_BIT = 7;
  localparam int PHASE_OFS_MSB     = 6;
  localparam int PHASE_OFS_LSB     = 4;
  localparam int FORCED_LOCK_MSB   = 3;
  localparam int FORCED_LOCK_LSB   = 0;

  // bandwidth select field layout
  localparam int SLICER_BW_MSB = 7;
  localparam int SLICER_BW_LSB = 6;
  localparam int INTEG_XO_MSB  = 5;
  localparam int INTEG_XO_LSB  = 4;
  localparam int LOOP_BW_MSB   = 3;
  localparam int LOOP_BW_LSB   = 2;
  localparam int LP_BW_MSB     = 1;
  localparam int LP_BW_LSB     = 0;

  // status register bits
  localparam int ST_RSVD_STICKY_BIT = 7;
  localparam int ST_RSVD_NOW_BIT    = 6;
  localparam int ST_MODE_MSB        = 2;
  localparam int ST_MODE_LSB        = 0;

  // forced lock state codes
  localparam logic [3:0] FLS_AUTO  = 4'h0;
  localparam logic [3:0] FLS_IN    = 4'h1;
  localparam logic [3:0] FLS_OUTER = 4'h4;
  localparam logic [3:0] FLS_INNER = 4'h6;
  localparam logic [3:0] FLS_HOLD  = 4'h8;

  // phase offset codes meaning correct equalisation and reserved, and the reserved two-bit field code
  localparam logic [2:0] PHASE_CORRECT = 3'h4;
  localparam logic [2:0] PHASE_RSVD    = 3'h0;
  localparam logic [1:0] CODE_RSVD_2B  = 2'h3;

  // loop operating mode presented to the datapath
  typedef enum logic [2:0] {
    BLC_MODE_AUTO     = 3'b000,
    BLC_MODE_IN_LOCK  = 3'b001,
    BLC_MODE_OUTER    = 3'b010,
    BLC_MODE_INNER    = 3'b011,
    BLC_MODE_HOLD     = 3'b100,
    BLC_MODE_RESERVED = 3'b111
  } blc_mode_t;

  // nominal clocks for the bandwidth tables, in Hz
  localparam longint NOM_SYS_CLK_HZ = 2150000;
  localparam longint NOM_BIT_CLK_HZ = 4300000;

  // frequency readback scale: f = value * converter clock / 128
  localparam int FREQ_READ_DIV = 128;

  // nominal bandwidth tables, in Hz, index = field code
  localparam longint SLICER_HZ [4] = '{12, 50, 200, 0};
  localparam longint INTEG_HZ  [4] = '{3780, 1890, 945, 0};
  localparam longint LOOP_HZ   [4] = '{21000, 10528, 5264, 2632};
  localparam longint LP_HZ     [4] = '{42100, 21000, 10528, 0};

endpackage

// ==== blc_regs.sv ====
// bit clock loop control registers with an avalon-mm slave port
//
// Local design decision: the Avalon-MM slave port.
module blc_regs #(
  parameter int     FREQ_W     = 10,
  parameter longint SYS_CLK_HZ = 100000000,
  parameter int     ADDR_W     = 4
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rstn,
  // avalon-mm slave, byte addressed
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic [31:0]            o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // observations from the loop datapath
  input  wire logic [FREQ_W-1:0] i_loop_freq_count,
  input  wire logic [7:0]        i_asymmetry_value,
  // controls toward the loop datapath
  output logic                   o_lock_override,
  output logic [2:0]             o_phase_offset_select,
  output logic signed [2:0]      o_phase_offset_eighths,
  output logic [3:0]             o_forced_lock_state,
  output logic [2:0]             o_loop_mode,
  output logic                   o_hold_mode,
  output logic [1:0]             o_slicer_bandwidth_select,
  output logic [1:0]             o_integrator_crossover_select,
  output logic [1:0]             o_loop_bandwidth_select_field,
  output logic [1:0]             o_lowpass_bandwidth_select,
  output logic [31:0]            o_slicer_bw_hz,
  output logic [31:0]            o_integ_xo_hz,
  output logic [31:0]            o_loop_bw_hz,
  output logic [31:0]            o_lowpass_bw_hz,
  output logic                   o_config_reserved
);

  // scale a nominal bandwidth to the real system clock, rounded down
  function automatic logic [31:0] scale_hz(input longint nom);
    longint r;
    r = (nom * SYS_CLK_HZ) / blc_pkg::NOM_SYS_CLK_HZ;
    scale_hz = r[31:0];
  endfunction

  // map a forced lock state code onto the loop mode
  function automatic blc_pkg::blc_mode_t lock_mode(input logic ovr, input logic [3:0] fls);
    blc_pkg::blc_mode_t m;
    m = blc_pkg::BLC_MODE_RESERVED;
    if (!ovr) begin
      m = (fls == blc_pkg::FLS_AUTO) ? blc_pkg::BLC_MODE_AUTO : blc_pkg::BLC_MODE_RESERVED;
    end else begin
      case (fls)
        blc_pkg::FLS_AUTO:  m = blc_pkg::BLC_MODE_AUTO;
        blc_pkg::FLS_IN:    m = blc_pkg::BLC_MODE_IN_LOCK;
        blc_pkg::FLS_OUTER: m = blc_pkg::BLC_MODE_OUTER;
        blc_pkg::FLS_INNER: m = blc_pkg::BLC_MODE_INNER;
        blc_pkg::FLS_HOLD:  m = blc_pkg::BLC_MODE_HOLD;
        default:            m = blc_pkg::BLC_MODE_RESERVED;
      endcase
    end
    lock_mode = m;
  endfunction

  // signed phase offset: over-equalised positive, under-equalised negative
  function automatic logic signed [2:0] phase_eighths(input logic [2:0] code);
    phase_eighths = 3'sh0;
    case (code)
      3'h1:    phase_eighths = 3'sh3;
      3'h2:    phase_eighths = 3'sh2;
      3'h3:    phase_eighths = 3'sh1;
      3'h5:    phase_eighths = -3'sh1;
      3'h6:    phase_eighths = -3'sh2;
      3'h7:    phase_eighths = -3'sh3;
      default: phase_eighths = 3'sh0;
    endcase
  endfunction

  // stored control images and bus state
  logic [7:0]  lock_sel_q;
  logic [7:0]  lock_sel_d;
  logic [7:0]  bw_sel_q;
  logic [7:0]  bw_sel_d;
  logic        rsvd_sticky_q;
  logic        rsvd_sticky_d;
  logic        ack_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // datapath-facing registered outputs
  logic        ovr_q;
  logic [2:0]  phase_q;
  logic signed [2:0] phase_e_q;
  logic [3:0]  fls_q;
  logic [2:0]  mode_q;
  logic        hold_q;
  logic [1:0]  slc_q;
  logic [1:0]  ixo_q;
  logic [1:0]  lbw_q;
  logic [1:0]  lpf_q;
  logic [31:0] slc_hz_q;
  logic [31:0] ixo_hz_q;
  logic [31:0] lbw_hz_q;
  logic [31:0] lpf_hz_q;
  logic        rsvd_q;

  // bus decode; the low two address bits are dropped, and writes need byte lane 0 enabled
  wire [7:0] word_idx    = 8'(i_avs_address >> 2);
  wire       req         = (i_avs_read | i_avs_write) & ~ack_q;
  wire       wr_take     = i_avs_write & ~ack_q;
  wire       rd_take     = i_avs_read & ~ack_q;
  wire       hit_lock    = (word_idx == blc_pkg::IDX_LOCK_SELECT);
  wire       hit_bw      = (word_idx == blc_pkg::IDX_BW_SELECT);
  wire       hit_status  = (word_idx == blc_pkg::IDX_STATUS);
  wire       lane0       = i_avs_byteenable[0];
  wire       wr_lock     = wr_take & hit_lock & lane0;
  wire       wr_bw       = wr_take & hit_bw & lane0;
  wire       wr_status   = wr_take & hit_status & lane0;

  // field views of the stored images
  wire       f_ovr = lock_sel_q[blc_pkg::LOCK_OVERRIDE_BIT];
  wire [2:0] f_pha = lock_sel_q[blc_pkg::PHASE_OFS_MSB:blc_pkg::PHASE_OFS_LSB];
  wire [3:0] f_fls = lock_sel_q[blc_pkg::FORCED_LOCK_MSB:blc_pkg::FORCED_LOCK_LSB];
  wire [1:0] f_slc = bw_sel_q[blc_pkg::SLICER_BW_MSB:blc_pkg::SLICER_BW_LSB];
  wire [1:0] f_ixo = bw_sel_q[blc_pkg::INTEG_XO_MSB:blc_pkg::INTEG_XO_LSB];
  wire [1:0] f_lbw = bw_sel_q[blc_pkg::LOOP_BW_MSB:blc_pkg::LOOP_BW_LSB];
  wire [1:0] f_lpf = bw_sel_q[blc_pkg::LP_BW_MSB:blc_pkg::LP_BW_LSB];

  // mode decode; with override clear, any state field other than automatic decodes as reserved
  wire blc_pkg::blc_mode_t mode_now = lock_mode(f_ovr, f_fls);

  // any reserved code currently stored; only the lock state and phase fall back to safe settings
  wire rsvd_pha  = (f_pha == blc_pkg::PHASE_RSVD);
  wire rsvd_mode = (mode_now == blc_pkg::BLC_MODE_RESERVED);
  wire rsvd_slc  = (f_slc == blc_pkg::CODE_RSVD_2B);
  wire rsvd_ixo  = (f_ixo == blc_pkg::CODE_RSVD_2B);
  wire rsvd_lpf  = (f_lpf == blc_pkg::CODE_RSVD_2B);
  wire rsvd_now  = rsvd_pha | rsvd_mode | rsvd_slc | rsvd_ixo | rsvd_lpf;

  // reserved lock state: keep the loop automatic rather than in an undefined mode
  wire [2:0] mode_safe = rsvd_mode ? 3'(blc_pkg::BLC_MODE_AUTO) : 3'(mode_now);
  // reserved phase code: treat as correct equalisation
  wire [2:0] pha_safe  = rsvd_pha ? blc_pkg::PHASE_CORRECT : f_pha;

  // frequency readback is the counter's top eight bits, scaled by 128 off-chip
  wire [7:0] freq_msb = i_loop_freq_count[FREQ_W-1 -: 8];

  // read mux: control registers read back loop observations, not written fields
  wire [7:0] status_byte = {rsvd_sticky_q, rsvd_now, 3'h0, mode_safe};
  wire [7:0] rd_byte = hit_lock   ? freq_msb :
                       hit_bw     ? i_asymmetry_value :
                       hit_status ? status_byte : 8'h00;

  // next values for the control images; a read never touches them
  assign lock_sel_d = wr_lock ? i_avs_writedata[7:0] : lock_sel_q;
  assign bw_sel_d   = wr_bw ? i_avs_writedata[7:0] : bw_sel_q;
  assign rdata_d    = rd_take ? {24'h0, rd_byte} : 32'h0;

  // sticky reserved flag; a new reserved code beats a simultaneous clear
  assign rsvd_sticky_d = rsvd_now |
                         (rsvd_sticky_q &
                          ~(wr_status & i_avs_writedata[blc_pkg::ST_RSVD_STICKY_BIT]));

  // bus handshake: one wait cycle, then a one-cycle release of waitrequest
  // waitrequest has its own flop so the pin sees no inverter after a register
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_q   <= 1'b0;
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      ack_q   <= req;
      wait_q  <= ~req;
      rdata_q <= rdata_d;
    end
  end

  // stored control images
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      lock_sel_q    <= blc_pkg::RST_LOCK_SELECT;
      bw_sel_q      <= blc_pkg::RST_BW_SELECT;
      rsvd_sticky_q <= 1'b0;
    end else begin
      lock_sel_q    <= lock_sel_d;
      bw_sel_q      <= bw_sel_d;
      rsvd_sticky_q <= rsvd_sticky_d;
    end
  end

  // lock controls toward the loop, registered so outputs come from flops
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ovr_q     <= 1'b0;
      phase_q   <= blc_pkg::PHASE_CORRECT;
      phase_e_q <= 3'sh0;
      fls_q     <= blc_pkg::FLS_AUTO;
      mode_q    <= 3'(blc_pkg::BLC_MODE_AUTO);
      hold_q    <= 1'b0;
      rsvd_q    <= 1'b0;
    end else begin
      ovr_q     <= f_ovr;
      phase_q   <= pha_safe;
      phase_e_q <= phase_eighths(pha_safe);
      fls_q     <= f_ovr ? f_fls : blc_pkg::FLS_AUTO;
      mode_q    <= mode_safe;
      hold_q    <= (mode_now == blc_pkg::BLC_MODE_HOLD);
      rsvd_q    <= rsvd_now;
    end
  end

  // bandwidth fields and their scaled values; tables are nominal at 2.15 MHz
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      slc_q    <= 2'h0;
      ixo_q    <= 2'h0;
      lbw_q    <= 2'h0;
      lpf_q    <= 2'h0;
      slc_hz_q <= 32'h0;
      ixo_hz_q <= 32'h0;
      lbw_hz_q <= 32'h0;
      lpf_hz_q <= 32'h0;
    end else begin
      slc_q    <= f_slc;
      ixo_q    <= f_ixo;
      lbw_q    <= f_lbw;
      lpf_q    <= f_lpf;
      slc_hz_q <= scale_hz(blc_pkg::SLICER_HZ[f_slc]);
      ixo_hz_q <= scale_hz(blc_pkg::INTEG_HZ[f_ixo]);
      lbw_hz_q <= scale_hz(blc_pkg::LOOP_HZ[f_lbw]);
      lpf_hz_q <= scale_hz(blc_pkg::LP_HZ[f_lpf]);
    end
  end

  // outputs straight from flops
  assign o_avs_waitrequest             = wait_q;
  assign o_avs_readdata                = rdata_q;
  assign o_lock_override               = ovr_q;
  assign o_phase_offset_select         = phase_q;
  assign o_phase_offset_eighths        = phase_e_q;
  assign o_forced_lock_state           = fls_q;
  assign o_loop_mode                   = mode_q;
  assign o_hold_mode                   = hold_q;
  assign o_slicer_bandwidth_select     = slc_q;
  assign o_integrator_crossover_select = ixo_q;
  assign o_loop_bandwidth_select_field = lbw_q;
  assign o_lowpass_bandwidth_select    = lpf_q;
  assign o_slicer_bw_hz                = slc_hz_q;
  assign o_integ_xo_hz                 = ixo_hz_q;
  assign o_loop_bw_hz                  = lbw_hz_q;
  assign o_lowpass_bw_hz               = lpf_hz_q;
  assign o_config_reserved             = rsvd_q;

endmodule

// ==== blc_regs_monitor.sv ====
// assertion checker for the bit clock loop control register bank
module blc_regs_monitor #(
  parameter int FREQ_W = 10,
  parameter int ADDR_W = 4
) (
  input wire logic              i_clk_sys,
  input wire logic              i_rstn,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic              i_avs_read,
  input wire logic              i_avs_write,
  input wire logic [31:0]       i_avs_writedata,
  input wire logic [3:0]        i_avs_byteenable,
  input wire logic [31:0]       o_avs_readdata,
  input wire logic              o_avs_waitrequest,
  input wire logic [FREQ_W-1:0] i_loop_freq_count,
  input wire logic [7:0]        i_asymmetry_value,
  input wire logic              o_lock_override,
  input wire logic [2:0]        o_phase_offset_select,
  input wire logic [3:0]        o_forced_lock_state,
  input wire logic [2:0]        o_loop_mode,
  input wire logic              o_hold_mode,
  input wire logic [1:0]        o_slicer_bandwidth_select,
  input wire logic [1:0]        o_integrator_crossover_select,
  input wire logic [1:0]        o_loop_bandwidth_select_field,
  input wire logic [1:0]        o_lowpass_bandwidth_select
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  // a request is taken while waitrequest is still high
  wire logic              take = o_avs_waitrequest && (i_avs_read || i_avs_write);
  wire logic [ADDR_W-3:0] idx  = i_avs_address[ADDR_W-1:2];
  wire logic              wr0  = take && i_avs_write && i_avs_byteenable[0] && (idx == 0);
  wire logic              wr1  = take && i_avs_write && i_avs_byteenable[0] && (idx == 1);
  logic [7:0]             wd_q;

  // keeps the taken write byte; no second take can land before the check
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) wd_q <= 8'h00;
    else if (take) wd_q <= i_avs_writedata[7:0];
  end

  AST_ANSWER: assert property (take |=> !o_avs_waitrequest)
    else $error("no answer one cycle after a request");
  AST_ONE_LOW: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_RD_IDLE: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0)
    else $error("read data not zero outside an answer");
  AST_FREQ_RD: assert property (take && i_avs_read && idx == 0 |=>
    o_avs_readdata == {24'h0, 8'($past(i_loop_freq_count) >> (FREQ_W - 8))})
    else $error("frequency readback wrong");
  AST_ASYM_RD: assert property (take && i_avs_read && idx == 1 |=>
    o_avs_readdata == {24'h0, $past(i_asymmetry_value)})
    else $error("asymmetry readback wrong");
  AST_HOLD: assert property (o_hold_mode ==
    (o_lock_override && o_forced_lock_state == 4'h8))
    else $error("hold flag disagrees with lock fields");
  AST_AUTO: assert property (!o_lock_override |-> o_forced_lock_state == 4'h0 &&
    o_loop_mode == 3'h0)
    else $error("automatic lock not shown with override clear");
  AST_LOCK_WR: assert property (wr0 |-> ##2 o_lock_override == wd_q[7] &&
    o_phase_offset_select == ((wd_q[6:4] == 3'h0) ? 3'h4 : wd_q[6:4]))
    else $error("lock select write not applied");
  AST_BW_WR: assert property (wr1 |-> ##2 {o_slicer_bandwidth_select,
    o_integrator_crossover_select, o_loop_bandwidth_select_field,
    o_lowpass_bandwidth_select} == wd_q)
    else $error("bandwidth select write not applied");

  COV_WRITE: cover property (wr1);
  COV_READ: cover property (take && i_avs_read && idx == 0);
  COV_HOLD: cover property (o_hold_mode);
endmodule

bind blc_regs blc_regs_monitor #(.FREQ_W(FREQ_W), .ADDR_W(ADDR_W)) u_blc_regs_monitor (
  .i_clk_sys, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_loop_freq_count,
  .i_asymmetry_value, .o_lock_override, .o_phase_offset_select, .o_forced_lock_state,
  .o_loop_mode, .o_hold_mode, .o_slicer_bandwidth_select, .o_integrator_crossover_select,
  .o_loop_bandwidth_select_field, .o_lowpass_bandwidth_select);

// ==== blc_regs_test.sv ====
// self-checking bench for the bit clock loop control register bank
module blc_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys = 1'b0, i_rstn = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [3:0]  i_avs_address = 4'h0, i_avs_byteenable = 4'hF;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [9:0]  i_loop_freq_count = 10'h000;
  logic [7:0]  i_asymmetry_value = 8'h00;
  logic [31:0] o_avs_readdata, o_slicer_bw_hz, o_integ_xo_hz, o_loop_bw_hz, o_lowpass_bw_hz;
  logic        o_avs_waitrequest, o_lock_override, o_hold_mode, o_config_reserved;
  logic [2:0]  o_phase_offset_select, o_loop_mode;
  logic signed [2:0] o_phase_offset_eighths;
  logic [3:0]  o_forced_lock_state;
  logic [1:0]  o_slicer_bandwidth_select, o_integrator_crossover_select;
  logic [1:0]  o_loop_bandwidth_select_field, o_lowpass_bandwidth_select;
  int          bad_count = 0;
  int          checked = 0;

  // nominal system clock so the scaled bandwidths equal the table values
  blc_regs #(.FREQ_W(10), .SYS_CLK_HZ(2150000), .ADDR_W(4)) u_blc_regs (
    .i_clk_sys, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_loop_freq_count,
    .i_asymmetry_value, .o_lock_override, .o_phase_offset_select, .o_phase_offset_eighths,
    .o_forced_lock_state, .o_loop_mode, .o_hold_mode, .o_slicer_bandwidth_select,
    .o_integrator_crossover_select, .o_loop_bandwidth_select_field,
    .o_lowpass_bandwidth_select, .o_slicer_bw_hz, .o_integ_xo_hz, .o_loop_bw_hz,
    .o_lowpass_bw_hz, .o_config_reserved);

  always #5 i_clk_sys = ~i_clk_sys;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus cycle; waits for waitrequest low, bounded, then releases
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      input logic be, output logic [31:0] q);
    int n;
    n = 0;
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, d};
    i_avs_byteenable <= {3'h7, be};
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    chk(32'(n < 20), 32'h1);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  // extra edge lets the control outputs follow the stored image
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, 1'b1, q);
    @(posedge i_clk_sys);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, 1'b1, q);
    chk(q, exp);
  endtask

  task automatic bw_fields(input logic [7:0] exp);
    chk({24'h0, o_slicer_bandwidth_select, o_integrator_crossover_select,
         o_loop_bandwidth_select_field, o_lowpass_bandwidth_select}, {24'h0, exp});
  endtask

  // reset twice: at start and at the end of the run after a hold setting
  task automatic do_reset();
    i_rstn <= 1'b0;
    repeat (20) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    chk({24'h0, o_lock_override, o_phase_offset_select, o_forced_lock_state}, 32'h40);
    chk({27'h0, o_loop_mode, o_hold_mode, o_config_reserved}, 32'h0);
    bw_fields(8'h00);
    chk(o_slicer_bw_hz + o_integ_xo_hz, 32'd3792);
    chk(o_loop_bw_hz + o_lowpass_bw_hz, 32'd63100);
  endtask

  // all phase codes, cycling through the five lock codes; status sticky set and cleared
  task automatic t_lock();
    logic [3:0] code [5] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h8};
    logic [2:0] ph;
    int k;
    for (int i = 0; i < 8; i++) begin
      k = i % 5;
      wr(4'h0, {1'b1, 3'(i), code[k]});
      ph = (i == 0) ? 3'h4 : 3'(i);
      chk({28'h0, o_lock_override, o_loop_mode}, {28'h0, 1'b1, 3'(k)});
      chk({28'h0, o_forced_lock_state}, {28'h0, code[k]});
      chk({31'h0, o_hold_mode}, 32'(k == 4));
      chk({29'h0, o_phase_offset_select}, {29'h0, ph});
      chk({29'h0, o_phase_offset_eighths}, {29'h0, 3'h4 - ph});
    end
    wr(4'h0, 8'hC3);
    chk({28'h0, o_config_reserved, o_loop_mode}, 32'h8);
    rd(4'h8, 32'hC0);
    wr(4'h0, 8'h40);
    chk({27'h0, o_lock_override, o_forced_lock_state}, 32'h0);
    rd(4'h8, 32'h80);
    wr(4'h8, 8'h80);
    rd(4'h8, 32'h00);
  endtask

  // every code of the four bandwidth fields at once
  task automatic t_bw();
    logic [31:0] sl [4] = '{32'd12, 32'd50, 32'd200, 32'd0};
    logic [31:0] ig [4] = '{32'd3780, 32'd1890, 32'd945, 32'd0};
    logic [31:0] lb [4] = '{32'd21000, 32'd10528, 32'd5264, 32'd2632};
    logic [31:0] lp [4] = '{32'd42100, 32'd21000, 32'd10528, 32'd0};
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(4'h4, {c, c, c, c});
      bw_fields({c, c, c, c});
      chk(o_slicer_bw_hz, sl[i]);
      chk(o_integ_xo_hz, ig[i]);
      chk(o_loop_bw_hz, lb[i]);
      chk(o_lowpass_bw_hz, lp[i]);
      chk({31'h0, o_config_reserved}, 32'(i == 3));
    end
    // a clear while a reserved code is stored must leave the sticky bit set
    wr(4'h8, 8'h80);
    rd(4'h8, 32'hC0);
  endtask

  // readback, unmapped and masked accesses leave the controls alone
  task automatic t_reads();
    logic [31:0] q;
    wr(4'h4, 8'h1B);
    i_loop_freq_count <= 10'h2B5;
    i_asymmetry_value <= 8'h9C;
    rd(4'h0, 32'hAD);
    rd(4'h4, 32'h9C);
    rd(4'hC, 32'h0);
    i_loop_freq_count <= 10'h3FF;
    rd(4'h0, 32'hFF);
    xfer(1'b1, 4'h4, 8'hFF, 1'b0, q);
    xfer(1'b1, 4'hC, 8'hFF, 1'b1, q);
    @(posedge i_clk_sys);
    bw_fields(8'h1B);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // the whole sequence needs well under 2000 cycles
  initial begin
    #100us;
    bad_count++;
    end_sim();
  end

  initial begin
    do_reset();
    t_lock();
    t_bw();
    t_reads();
    wr(4'h0, 8'h98);
    do_reset();
    end_sim();
  end
endmodule
